//--- common/wds_params.svh
// Summary of operation
// - Watchdog runs enabled after every srst or watchdog reset, no software action needed; porRst alone leaves it as it was.
// - Disable requests work only until end-of-init executes; ignored afterwards.
// - Overflow raises internal hardware reset and pulls reset-out pin low.
// - Counter is sixteen bits, split into high and low byte.
// - Counter advances at system clock divided by two or by 128.
// - Programmable reload value loads into counter high byte.
// - Software services before overflow; each service reloads the high byte.
// - Reset settings give 6.55 ms to overflow at 20 MHz clock.
// - Overflow is a reset source sharing reset vector zero.
// - End-of-init releases reset-out pin and closes the disable window.
`ifndef WDS_PARAMS_SVH
`define WDS_PARAMS_SVH

// counter layout
`define WDS_CNT_W 16
`define WDS_BYTE_W 8
`define WDS_CNT_MAX 16'hFFFF
`define WDS_LOW_CLR 8'h00

// prescaler
`define WDS_PRE_W 7
`define WDS_DIV_SLOW 7'h7F
`define WDS_DIV_FAST 7'h01
`define WDS_PRE_CLR 7'h00

// reset values
`define WDS_RELOAD_RST 8'h00
`define WDS_SEL128_RST 1'b0

// reset source and vector
`define WDS_VECTOR_W 24
`define WDS_RESET_VECTOR 24'h000000

// internal reset pulse length
`define WDS_RST_HOLD_CYC 16
`define WDS_HOLD_W 5
`define WDS_WRAP_W 8
`define WDS_WRAP_MAX 8'hFF

`endif

//--- common/wds_pkg.sv
package wds_pkg;

  // watchdog state: gray along run -> fire
  typedef enum logic [1:0] {
    WDS_RUN = 2'b00,
    WDS_FIRE = 2'b01,
    WDS_OFF = 2'b10
  } wds_state_t;

  // commands from the cpu core, same clock
  typedef struct packed {
    logic service;
    logic disableReq;
    logic endInit;
    logic loadCfg;
    logic sel128;
    logic [7:0] reloadVal;
    logic clrSrcFlag;
  } wds_cmd_t;

  // state seen by the core
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] reloadVal;
    logic sel128;
    logic enabled;
    logic initDone;
    logic wdtSrcFlag;
    logic [7:0] wrapCount;
  } wds_stat_t;

endpackage

//--- logic/wds_watchdog.sv
`timescale 1ns/1ps
`include "wds_params.svh"

module wds_watchdog
  import wds_pkg::*;
#(
  parameter int RST_HOLD = `WDS_RST_HOLD_CYC
) (
  // clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic porRst,
  // core commands
  input wds_cmd_t cmd,
  // status to core
  output wds_stat_t stat,
  // reset outputs
  output logic hwResetReq,
  output logic resetOutN,
  output logic [`WDS_VECTOR_W-1:0] resetVector
);

  wds_state_t state_ff, nxt_state;
  logic [`WDS_CNT_W-1:0] count_ff, nxt_count;
  logic [`WDS_PRE_W-1:0] pre_ff, nxt_pre;
  logic [`WDS_BYTE_W-1:0] reload_ff, nxt_reload;
  logic sel128_ff, nxt_sel128;
  logic initDone_ff, nxt_initDone;
  logic [`WDS_HOLD_W-1:0] hold_ff, nxt_hold;
  logic srcFlag_ff, nxt_srcFlag;
  logic [`WDS_WRAP_W-1:0] wrap_ff, nxt_wrap;
  logic hwReset_ff;
  logic resetOutN_ff;

  // decode
  wire logic [`WDS_PRE_W-1:0] divLast = sel128_ff ? `WDS_DIV_SLOW : `WDS_DIV_FAST;
  wire logic tick = (pre_ff >= divLast);
  wire logic running = (state_ff == WDS_RUN);
  wire logic cntFull = (count_ff == `WDS_CNT_MAX);
  wire logic overflow = running && tick && cntFull && !cmd.service;
  wire logic holdDone = (hold_ff == RST_HOLD[`WDS_HOLD_W-1:0] - 1'b1);
  wire logic fireEnd = (state_ff == WDS_FIRE) && holdDone;
  // internal reset: external reset or end of the watchdog reset pulse
  wire logic anyRst = srst || fireEnd;
  wire logic canDisable = !initDone_ff && (state_ff != WDS_FIRE);
  wire logic doDisable = cmd.disableReq && canDisable;
  wire logic doService = cmd.service && (state_ff != WDS_FIRE);
  wire logic [`WDS_CNT_W-1:0] reloadWord = {reload_ff, `WDS_LOW_CLR};
  wire logic [`WDS_CNT_W-1:0] countInc = count_ff + 16'h0001;

  // state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      WDS_RUN: begin
        if (overflow) begin
          nxt_state = WDS_FIRE;
        end else if (doDisable) begin
          nxt_state = WDS_OFF;
        end
      end
      WDS_OFF: begin
        nxt_state = WDS_OFF;
      end
      WDS_FIRE: begin
        nxt_state = WDS_FIRE;
      end
      default: begin
        nxt_state = WDS_RUN;
      end
    endcase
    if (anyRst) begin
      nxt_state = WDS_RUN;
    end
  end

  // prescaler
  always_comb begin
    nxt_pre = tick ? `WDS_PRE_CLR : pre_ff + 7'h01;
    if (anyRst || doService || !running) begin
      nxt_pre = `WDS_PRE_CLR;
    end
  end

  // counter: up count, reload on service
  always_comb begin
    nxt_count = count_ff;
    if (running && tick) begin
      nxt_count = countInc;
    end
    if (doService) begin
      nxt_count = reloadWord;
    end
    if (anyRst) begin
      nxt_count = {`WDS_RELOAD_RST, `WDS_LOW_CLR};
    end
  end

  // reload value and prescaler select
  always_comb begin
    nxt_reload = reload_ff;
    nxt_sel128 = sel128_ff;
    if (cmd.loadCfg) begin
      nxt_reload = cmd.reloadVal;
      nxt_sel128 = cmd.sel128;
    end
    if (anyRst) begin
      nxt_reload = `WDS_RELOAD_RST;
      nxt_sel128 = `WDS_SEL128_RST;
    end
  end

  // end of initialisation
  always_comb begin
    nxt_initDone = initDone_ff;
    if (cmd.endInit && (state_ff != WDS_FIRE)) begin
      nxt_initDone = 1'b1;
    end
    if (anyRst) begin
      nxt_initDone = 1'b0;
    end
  end

  // reset pulse length
  always_comb begin
    nxt_hold = hold_ff;
    if (state_ff == WDS_FIRE) begin
      nxt_hold = hold_ff + 5'h01;
    end
    if (anyRst || overflow) begin
      nxt_hold = '0;
    end
  end

  // reset source flag: set wins over clear, survives internal resets
  always_comb begin
    nxt_srcFlag = srcFlag_ff;
    if (cmd.clrSrcFlag) begin
      nxt_srcFlag = 1'b0;
    end
    if (overflow) begin
      nxt_srcFlag = 1'b1;
    end
  end

  always_comb begin
    nxt_wrap = wrap_ff;
    if (overflow && (wrap_ff != `WDS_WRAP_MAX)) begin
      nxt_wrap = wrap_ff + 8'h01;
    end
  end

  // registers cleared by srst or by the end of the watchdog reset pulse, not by porRst
  always_ff @(posedge clk) begin
    state_ff <= nxt_state;
  end

  always_ff @(posedge clk) begin
    count_ff <= nxt_count;
  end

  always_ff @(posedge clk) begin
    pre_ff <= nxt_pre;
  end

  always_ff @(posedge clk) begin
    reload_ff <= nxt_reload;
  end

  always_ff @(posedge clk) begin
    sel128_ff <= nxt_sel128;
  end

  always_ff @(posedge clk) begin
    initDone_ff <= nxt_initDone;
  end

  always_ff @(posedge clk) begin
    hold_ff <= nxt_hold;
  end

  // registers reset only at power-on; the source flag is also cleared by clrSrcFlag
  always_ff @(posedge clk) begin
    if (porRst) begin
      srcFlag_ff <= 1'b0;
    end else begin
      srcFlag_ff <= nxt_srcFlag;
    end
  end

  always_ff @(posedge clk) begin
    if (porRst) begin
      wrap_ff <= '0;
    end else begin
      wrap_ff <= nxt_wrap;
    end
  end

  // output pins
  always_ff @(posedge clk) begin
    if (anyRst) begin
      hwReset_ff <= 1'b0;
    end else begin
      hwReset_ff <= (nxt_state == WDS_FIRE);
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      resetOutN_ff <= 1'b0;
    end else begin
      resetOutN_ff <= nxt_initDone && (nxt_state != WDS_FIRE);
    end
  end

  assign hwResetReq = hwReset_ff;
  assign resetOutN = resetOutN_ff;
  assign resetVector = `WDS_RESET_VECTOR;
  assign stat.count = count_ff;
  assign stat.reloadVal = reload_ff;
  assign stat.sel128 = sel128_ff;
  assign stat.enabled = running;
  assign stat.initDone = initDone_ff;
  assign stat.wdtSrcFlag = srcFlag_ff;
  assign stat.wrapCount = wrap_ff;

endmodule // wds_watchdog

//--- verif/wds_props.sv
`timescale 1ns/1ps
module wds_props
  import wds_pkg::*;
#(parameter int RST_HOLD = 2) (
  // watched ports
  input wire logic clk,
  input wire logic srst,
  input wire logic porRst,
  input wds_cmd_t cmd,
  input wds_stat_t stat,
  input wire logic hwResetReq,
  input wire logic resetOutN,
  input wire logic [23:0] resetVector
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_rst_state: assert property ($fell(srst) |-> stat.enabled && stat.count == 16'h0000 &&
    !stat.sel128 && stat.reloadVal == 8'h00) else $error("reset state wrong");
  a_vec_zero: assert property (resetVector == 24'h000000) else $error("vector wrong");
  a_dis_lock: assert property (stat.initDone && stat.enabled && cmd.disableReq &&
    !hwResetReq && stat.count != 16'hFFFF |=> stat.enabled) else $error("late disable");
  a_srv_load: assert property (cmd.service && !cmd.loadCfg && !hwResetReq
    |=> stat.count == {stat.reloadVal, 8'h00}) else $error("service load wrong");
  a_ovf_fire: assert property ($rose(hwResetReq) |-> !resetOutN &&
    $past(stat.count) == 16'hFFFF) else $error("overflow wrong");
  a_hold_len: assert property ($rose(hwResetReq) |-> hwResetReq[*2] ##1
    (!hwResetReq && stat.enabled && stat.wdtSrcFlag)) else $error("reset pulse wrong");
  a_div2_rate: assert property ((stat.enabled && !stat.sel128 && !hwResetReq &&
    stat.count != 16'hFFFF && cmd == '0)[*3] |-> stat.count != $past(stat.count, 2))
    else $error("div2 rate wrong");
  a_div128_rate: assert property ((stat.sel128 && cmd == '0 && !hwResetReq)[*2] ##0
    $changed(stat.count) |=> ($stable(stat.count) || $past(cmd) != '0 || !stat.sel128)[*8])
    else $error("div128 rate wrong");
  a_init_rel: assert property (cmd.endInit && !hwResetReq && stat.count != 16'hFFFF
    |=> resetOutN && stat.initDone) else $error("end of init wrong");
  cover property ($rose(hwResetReq));
  cover property (cmd.service && stat.sel128);
  cover property (cmd.disableReq && stat.initDone);
endmodule // wds_props
bind wds_watchdog wds_props #(.RST_HOLD(RST_HOLD)) u_props (.clk(clk), .srst(srst),
  .porRst(porRst), .cmd(cmd), .stat(stat), .hwResetReq(hwResetReq),
  .resetOutN(resetOutN), .resetVector(resetVector));

//--- verif/wds_ext_dev.sv
`timescale 1ns/1ps
module wds_ext_dev (
  // pin from device
  input wire logic clk,
  input wire logic resetOutN,
  // resets seen
  output int resets
);
  logic prevN_ff = 1'b0;
  initial resets = 0;
  always @(posedge clk) begin
    prevN_ff <= resetOutN;
    if (prevN_ff && !resetOutN) resets <= resets + 1;
  end
endmodule // wds_ext_dev

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import wds_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic porRst = 1'b1;
  wds_cmd_t cmd = '0;
  wds_stat_t stat;
  logic hwResetReq, resetOutN;
  logic [23:0] resetVector;
  logic [7:0] r;
  logic s;
  logic [15:0] d;
  int resets, seed, mismatches = 0, cmp_count = 0;
  wds_watchdog #(.RST_HOLD(2)) DUT (.clk(clk), .srst(srst), .porRst(porRst), .cmd(cmd),
    .stat(stat), .hwResetReq(hwResetReq), .resetOutN(resetOutN), .resetVector(resetVector));
  wds_ext_dev ext (.clk(clk), .resetOutN(resetOutN), .resets(resets));
  always #12.5 clk = ~clk;
  function automatic logic [15:0] svc(logic [7:0] v);
    return {v, 8'h00};
  endfunction
  function automatic int lo(int n, logic sl);
    return sl ? n / 128 : n / 2;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic go(int k, logic [7:0] v, logic sl);
    wds_cmd_t c;
    c = '0;
    c.service = (k == 0);
    c.disableReq = (k == 1);
    c.endInit = (k == 2);
    c.loadCfg = (k == 3);
    c.clrSrcFlag = (k == 4);
    c.reloadVal = v;
    c.sel128 = sl;
    cmd = c;
    cyc(1);
    cmd = '0;
    cyc(1);
  endtask
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    seed = $urandom(32'hF1726B05);
    cyc(10);
    srst = 1'b0;
    porRst = 1'b0;
    chk({stat.enabled, stat.count, stat.reloadVal, stat.sel128, resetOutN}, {1'b1, 26'h0});
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      r = 8'($urandom);
      s = 1'($urandom);
      go(3, r, s);
      go(0, 8'h00, 1'b0);
      chk(stat.count, svc(r));
      cyc(260);
      d = stat.count - svc(r);
      chk(d == lo(260, s) || d + 1 == lo(260, s), 1);
    end
    $display("service test done");
    go(2, 8'h00, 1'b0);
    chk({resetOutN, stat.initDone}, 2'b11);
    go(1, 8'h00, 1'b0);
    chk(stat.enabled, 1);
    $display("init test done");
    go(3, 8'hFF, 1'b0);
    go(0, 8'h00, 1'b0);
    for (int k = 0; k < 600 && hwResetReq !== 1'b1; k++) cyc(1);
    chk({hwResetReq, resetOutN, stat.enabled, resetVector}, {3'b100, 24'h0});
    cyc(4);
    chk({hwResetReq, stat.wdtSrcFlag, stat.enabled, stat.initDone}, 4'b0110);
    chk(resets, 1);
    chk(stat.wrapCount, 1);
    go(4, 8'h00, 1'b0);
    chk(stat.wdtSrcFlag, 0);
    go(1, 8'h00, 1'b0);
    chk(stat.enabled, 0);
    porRst = 1'b1;
    cyc(1);
    porRst = 1'b0;
    chk({stat.wdtSrcFlag, stat.wrapCount}, 9'h000);
    $display("overflow test done");
    conclude();
  end
  initial begin
    cyc(20000);
    mismatches++;
    conclude();
  end
endmodule // testbench
